// file: dv/irc_readout_host_bench.sv
// Self-checking bench for the row readout controller
`timescale 1ns/1ps
module irc_readout_host_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic row_clock, row_sync, row_blank, col_pre, sh, avg, pre_a, pre_b;
    logic pix_clock, col_sync, cfg_data, cfg_clock, cfg_load, line_end, cfg_check;
    logic pix_q = 1'b0;
    logic sh_seen = 1'b0;
    int pix_rises = 0;
    int pre_pulses = 0;
    int avg_cycles = 0;
    int err_count = 0;
    int check_count = 0;

    initial forever #5 clk = ~clk;

    irc_readout_host i_irc_readout_host (.CLOCK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
        .ROW_CLOCK_O(row_clock), .ROW_SYNC_O(row_sync), .ROW_BLANK_O(row_blank),
        .COL_PRECHARGE_O(col_pre), .COLUMN_SAMPLE_HOLD_O(sh), .VOLT_AVG_O(avg),
        .BUS_PRECHARGE_A_O(pre_a), .BUS_PRECHARGE_B_O(pre_b), .PIX_CLOCK_O(pix_clock),
        .COL_SYNC_O(col_sync), .CFG_DATA_O(cfg_data), .CFG_CLOCK_O(cfg_clock),
        .CFG_LOAD_O(cfg_load), .LINE_END_I(line_end), .CFG_CHECK_I(cfg_check));

    irc_sensor_model #(.LINE_PIX(3)) i_irc_sensor_model (.row_sync_i(row_sync),
        .row_clock_i(row_clock), .col_sync_i(col_sync), .pix_clock_i(pix_clock),
        .cfg_data_i(cfg_data), .cfg_clock_i(cfg_clock), .cfg_load_i(cfg_load),
        .line_end_o(line_end), .cfg_check_o(cfg_check));

    // Counts pixel clocks, precharge pulses and averaging cycles; flags any sample-hold high
    always @(posedge clk) begin
        pix_q <= pix_clock;
        if (pix_clock && !pix_q) pix_rises++;
        if (pre_a) pre_pulses++;
        if (avg) avg_cycles++;
        if (sh) sh_seen = 1'b1;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        for (int i = 0; i < 1000; i++) begin
            rd_reg(irc_pkg::OFS_STAT, s);
            if (s[1:0] === 2'b00) return;
        end
        err_count++;
        $display("ERROR idle wait expected idle seen busy");
        tally_and_finish();
    endtask

    task automatic t_regs();
        logic [7:0] a[6] = '{irc_pkg::OFS_CFG, irc_pkg::OFS_CTRL, irc_pkg::OFS_LINES,
            irc_pkg::OFS_COLS, irc_pkg::OFS_SHLEN, 8'h1C};
        logic [31:0] e[6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0800, 32'h0000_0400,
            32'h0000_0014, 32'h0000_0000};
        logic [31:0] v;
        for (int i = 0; i < 6; i++) begin
            rd_reg(a[i], v);
            chk("reset value", e[i], v);
        end
    endtask

    task automatic t_cfg();
        logic [31:0] w[2] = '{32'h0000_0000, 32'hA5C3_0E69};
        logic [31:0] v;
        wr_reg(irc_pkg::OFS_CFG, 32'h0000_5000);
        rd_reg(irc_pkg::OFS_CFG, v);
        chk("subsample column even", 32'h0000_1000, v);
        for (int i = 0; i < 2; i++) begin
            v = i_irc_sensor_model.work_q;
            wr_reg(irc_pkg::OFS_CFG, w[i]);
            wr_reg(irc_pkg::OFS_CTRL, 32'h0000_0100);
            // Most of the word is in the chain by now; the working word must not move yet
            repeat (200) @(posedge clk);
            chk("word before load", v, i_irc_sensor_model.work_q);
            wait_idle();
            chk("working word", w[i], i_irc_sensor_model.work_q);
            rd_reg(irc_pkg::OFS_STAT, v);
            chk("chain check", {31'h0000_0000, w[i][31]}, {31'h0000_0000, v[2]});
        end
    endtask

    task automatic t_frame(input logic [31:0] ctrl);
        logic [31:0] v;
        pix_rises = 0;
        pre_pulses = 0;
        avg_cycles = 0;
        sh_seen = 1'b0;
        wr_reg(irc_pkg::OFS_CTRL, ctrl | 32'h0000_0200);
        wr_reg(irc_pkg::OFS_CFG, 32'hFFFF_FFFF);
        wait_idle();
        rd_reg(irc_pkg::OFS_CFG, v);
        chk("config kept in frame", 32'hA5C3_0E69, v);
        chk("pixel clocks", 32'h0000_0006, pix_rises);
        chk("precharge pulses", ctrl[1] ? 32'h0000_0002 : 32'h0000_0000, pre_pulses);
        chk("sample hold high", {31'h0000_0000, ctrl[0]}, {31'h0000_0000, sh_seen});
        chk("averaging cycles", (ctrl[2] & ctrl[0]) ? 32'h0000_0006 : 32'h0000_0000,
            avg_cycles);
        chk("column start", {21'h00_0000, 11'h618},
            {21'h00_0000, i_irc_sensor_model.col_q});
        rd_reg(irc_pkg::OFS_STAT, v);
        chk("line end flag", 32'h0000_0001, {31'h0000_0000, v[3]});
    endtask

    task automatic t_shlen();
        logic [31:0] v;
        wr_reg(irc_pkg::OFS_SHLEN, 32'h0000_0005);
        rd_reg(irc_pkg::OFS_SHLEN, v);
        chk("sample hold clamp", 32'h0000_000A, v);
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_cfg();
        wr_reg(irc_pkg::OFS_LINES, 32'h0000_0002);
        wr_reg(irc_pkg::OFS_COLS, 32'h0000_0003);
        t_frame(32'h0000_0002);
        t_shlen();
        t_frame(32'h0000_0007);
        tally_and_finish();
    end
endmodule // irc_readout_host_bench

bind irc_readout_host irc_readout_host_checker i_irc_readout_host_checker (.CLOCK_I,
    .SYS_RST_I, .ROW_SYNC_O, .ROW_CLOCK_O, .ROW_BLANK_O, .COL_PRECHARGE_O,
    .COLUMN_SAMPLE_HOLD_O, .VOLT_AVG_O, .BUS_PRECHARGE_A_O, .BUS_PRECHARGE_B_O,
    .PIX_CLOCK_O, .CFG_CLOCK_O, .CFG_LOAD_O);

// file: dv/irc_readout_host_checker.sv
// Concurrent checks on the readout strobes and the configuration link
`timescale 1ns/1ps
module irc_readout_host_checker (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic ROW_SYNC_O,
    input wire logic ROW_CLOCK_O,
    input wire logic ROW_BLANK_O,
    input wire logic COL_PRECHARGE_O,
    input wire logic COLUMN_SAMPLE_HOLD_O,
    input wire logic VOLT_AVG_O,
    input wire logic BUS_PRECHARGE_A_O,
    input wire logic BUS_PRECHARGE_B_O,
    input wire logic PIX_CLOCK_O,
    input wire logic CFG_CLOCK_O,
    input wire logic CFG_LOAD_O
);
    logic [7:0] since_blank_q;
    logic [7:0] sh_low_q;
    logic cfg_clk_q;
    logic [5:0] bit_cnt_q;
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            since_blank_q <= 8'h00;
            sh_low_q <= 8'h00;
            cfg_clk_q <= 1'b0;
            bit_cnt_q <= 6'h00;
        end else begin
            since_blank_q <= ROW_BLANK_O ? 8'h00 : since_blank_q + {7'h00, since_blank_q != 8'hFF};
            sh_low_q <= COLUMN_SAMPLE_HOLD_O ? 8'h00 : sh_low_q + {7'h00, sh_low_q != 8'hFF};
            cfg_clk_q <= CFG_CLOCK_O;
            bit_cnt_q <= CFG_LOAD_O ? 6'h00 : bit_cnt_q + {5'h00, CFG_CLOCK_O & ~cfg_clk_q};
        end
    end
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (SYS_RST_I);
    sequence s_blank;
        ROW_BLANK_O [*2] ##1 !ROW_BLANK_O;
    endsequence
    sequence s_sync;
        ROW_SYNC_O [*4] ##1 !ROW_SYNC_O;
    endsequence
    sequence s_avg;
        VOLT_AVG_O [*3] ##1 !VOLT_AVG_O;
    endsequence
    a_blank_pre_pair: assert property (ROW_BLANK_O == COL_PRECHARGE_O)
        else $error("blank and column precharge differ");
    a_blank_two_cycles: assert property ($rose(ROW_BLANK_O) |-> s_blank)
        else $error("blank strobe length wrong");
    a_rot_wait_std: assert property ($rose(PIX_CLOCK_O) && !COLUMN_SAMPLE_HOLD_O
        && since_blank_q < 8'h28 |-> since_blank_q >= 8'h12)
        else $error("pixel clock too soon after strobes");
    a_sh_with_blank: assert property ($rose(ROW_BLANK_O) && $past(COLUMN_SAMPLE_HOLD_O)
        |-> $fell(COLUMN_SAMPLE_HOLD_O))
        else $error("sample hold pulse not started with blank");
    a_sh_pulse_len: assert property ($rose(COLUMN_SAMPLE_HOLD_O) && sh_low_q < 8'h28
        |-> sh_low_q >= 8'h0A && sh_low_q <= 8'h14)
        else $error("sample hold pulse length out of range");
    a_avg_after_sh: assert property ($rose(VOLT_AVG_O) |-> COLUMN_SAMPLE_HOLD_O
        && !PIX_CLOCK_O ##0 s_avg)
        else $error("averaging pulse misplaced or short");
    a_bus_pre_pair: assert property (BUS_PRECHARGE_A_O == BUS_PRECHARGE_B_O)
        else $error("bus precharge outputs differ");
    a_bus_pre_short: assert property ($rose(BUS_PRECHARGE_A_O) |-> ROW_BLANK_O
        ##1 !BUS_PRECHARGE_A_O)
        else $error("bus precharge pulse wrong");
    a_sync_len: assert property ($rose(ROW_SYNC_O) |-> s_sync)
        else $error("row sync length wrong");
    a_sync_clock: assert property ($rose(ROW_SYNC_O) |-> ##[1:3] (ROW_SYNC_O
        && $rose(ROW_CLOCK_O)))
        else $error("no row clock rise within sync");
    a_load_all_bits: assert property ($rose(CFG_LOAD_O) |-> bit_cnt_q == 6'h20)
        else $error("load before all bits shifted");
    a_load_quiet: assert property (CFG_LOAD_O |-> !CFG_CLOCK_O)
        else $error("link clock during load");
endmodule // irc_readout_host_checker

// file: dv/irc_sensor_model.sv
// Behavioural sensor model: configuration chain, address counters and test flags
`timescale 1ns/1ps
module irc_sensor_model #(
    parameter int LINE_PIX = 3
) (
    input wire logic row_sync_i,
    input wire logic row_clock_i,
    input wire logic col_sync_i,
    input wire logic pix_clock_i,
    input wire logic cfg_data_i,
    input wire logic cfg_clock_i,
    input wire logic cfg_load_i,
    output logic line_end_o,
    output logic cfg_check_o
);
    logic [31:0] shift_q = 32'h0000_0000;
    logic [31:0] work_q = 32'h0000_0000;
    logic [10:0] col_q = 11'h000;
    logic [10:0] row_q = 11'h000;
    int pix_cnt = 0;
    // Chain fills on rising link clock, first bit ends on top
    always @(posedge cfg_clock_i) shift_q <= {shift_q[30:0], cfg_data_i};
    always @(posedge cfg_load_i) work_q <= shift_q;
    assign cfg_check_o = shift_q[31];
    always @(posedge row_clock_i) begin
        row_q <= row_sync_i ? {work_q[10:1], 1'b0} : row_q + 11'h001;
    end
    always @(posedge pix_clock_i) begin
        if (col_sync_i) begin
            col_q <= {work_q[23:14], 1'b0};
            pix_cnt <= 1;
        end else begin
            pix_cnt <= pix_cnt + 1;
        end
    end
    assign line_end_o = (pix_cnt == LINE_PIX);
endmodule // irc_sensor_model

// file: pkg/irc_pkg.sv
// Constants, register map and state types of the row readout controller
package irc_pkg;
    localparam int CLK_NS = 10;
    localparam int BLANK_NS = 20;
    localparam int ROT_NS = 180;
    localparam int SH_MIN_NS = 100;
    localparam int SH_MAX_NS = 200;
    localparam int AVG_NS = 20;
    localparam int PRE_NS = 5;
    localparam int SYNC_NS = 20;
    // Least times round up; strict lower bounds add one cycle
    localparam logic [7:0] BLANK_CYC = 8'((BLANK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ROT_CYC = 8'((ROT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] AVG_CYC = 8'(AVG_NS / CLK_NS + 1);
    localparam logic [7:0] PRE_CYC = 8'((PRE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] SYNC_CYC = 8'(SYNC_NS / CLK_NS + 1);
    localparam logic [4:0] SH_MIN_CYC = 5'((SH_MIN_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] SH_MAX_CYC = 5'(SH_MAX_NS / CLK_NS);

    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_LINES = 8'h08;
    localparam logic [7:0] OFS_COLS = 8'h0C;
    localparam logic [7:0] OFS_SHLEN = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;

    localparam int CTRL_BACKUP = 0;
    localparam int CTRL_BUSPRE = 1;
    localparam int CTRL_AVG = 2;
    localparam int CTRL_SEND = 8;
    localparam int CTRL_START = 9;
    localparam int STAT_CFG_BUSY = 0;
    localparam int STAT_FRAME_BUSY = 1;
    localparam int STAT_CFG_CHECK = 2;
    localparam int STAT_LINE_END = 3;
    localparam int STAT_LINE_LSB = 16;

    localparam int CFG_YDIR = 0;
    localparam int CFG_YADDR_LSB = 1;
    localparam int CFG_AVG = 11;
    localparam int CFG_SUB = 12;
    localparam int CFG_XDIR = 13;
    localparam int CFG_XADDR_LSB = 14;
    localparam int CFG_OUTS = 24;
    localparam int CFG_DAC_LSB = 25;

    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [11:0] LINES_RST = 12'h800;
    localparam logic [11:0] COLS_RST = 12'h400;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_FSYNC = 8'h02,
        ST_BLANK = 8'h04,
        ST_ROTW = 8'h08,
        ST_AVG = 8'h10,
        ST_XSYNC = 8'h20,
        ST_PIX = 8'h40,
        ST_LINE = 8'h80
    } irc_state_t;

    typedef enum logic [2:0] {
        CS_IDLE = 3'h1,
        CS_SHIFT = 3'h2,
        CS_LOAD = 3'h4
    } irc_cfg_state_t;
endpackage

// file: rtl/irc_cfg_serial.sv
// Serialiser that shifts the configuration word out and pulses the load pin
`timescale 1ns/1ps
module irc_cfg_serial #(
    parameter int WIDTH = 32,
    parameter int DIV = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [WIDTH-1:0] word_i,
    output logic busy_o,
    output logic data_o,
    output logic clock_o,
    output logic load_o
);
    generate
        if (WIDTH < 2 || DIV < 1 || DIV > 255) begin : g_bad
            $error("irc_cfg_serial: unsupported WIDTH or DIV");
        end
    endgenerate

    irc_pkg::irc_cfg_state_t state_q;
    logic [WIDTH-1:0] sreg_q;
    logic [7:0] div_q;
    logic [7:0] bit_q;
    logic phase_q;
    wire tick_w = (div_q == 8'(DIV - 1));
    wire last_w = (bit_q == 8'h00);

    assign busy_o = (state_q != irc_pkg::CS_IDLE);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= irc_pkg::CS_IDLE;
            sreg_q <= '0;
            div_q <= 8'h00;
            bit_q <= 8'h00;
            phase_q <= 1'b0;
            data_o <= 1'b0;
            clock_o <= 1'b0;
            load_o <= 1'b0;
        end else begin
            div_q <= (state_q == irc_pkg::CS_IDLE || tick_w) ? 8'h00 : div_q + 8'h01;
            unique case (state_q)
                irc_pkg::CS_IDLE: begin
                    if (start_i) begin
                        state_q <= irc_pkg::CS_SHIFT;
                        sreg_q <= word_i;
                        data_o <= word_i[WIDTH-1];
                        bit_q <= 8'(WIDTH - 1);
                        phase_q <= 1'b0;
                    end
                end
                irc_pkg::CS_SHIFT: begin
                    if (tick_w) begin
                        phase_q <= ~phase_q;
                        clock_o <= ~phase_q;
                        if (phase_q && last_w) begin
                            state_q <= irc_pkg::CS_LOAD; // [R23]
                            load_o <= 1'b1; // [R16]
                        end else if (phase_q) begin
                            sreg_q <= {sreg_q[WIDTH-2:0], 1'b0};
                            data_o <= sreg_q[WIDTH-2];
                            bit_q <= bit_q - 8'h01;
                        end
                    end
                end
                irc_pkg::CS_LOAD: begin
                    if (tick_w) begin
                        load_o <= 1'b0;
                        state_q <= irc_pkg::CS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // irc_cfg_serial

// file: rtl/irc_readout_host.sv
// Camera-side controller driving sensor row readout strobes and configuration link
// How it works
// [R1] Standard: blanking and precharge strobes about 20 ns
// [R2] Standard: wait 180 ns before first pixel
// [R3] Standard: sample-hold held low whole readout
// [R4] Backup: columns track during sample-hold pulse
// [R5] Backup: sample-hold pulse 100-200 ns with strobes
// [R6] Averaging: backup mode, pulse after sample-hold
// [R7] Averaging pulse lasts longer than 20 ns
// [R8] Bus precharge: short pulse on both inputs
// [R9] Bus precharge combines with either row mode
// [R10] Word: scan direction, row address, averaging, outputs
// [R11] Bit 13 sets column scan direction
// [R12] Bits 14-23 hold column start address
// [R13] Bits 25-31 hold seven-bit DAC setting
// [R14] Subsampling demands even column start address
// [R15] All-zero word gives default readout setup
// [R16] Device adopts word only on load pulse
// [R17] Line sync resets columns; end-of-line flagged
// [R18] Check output shows serial chain integrity
// [R19] Effective start address is field times two
// [R20] Row sync dominates and reinitialises rows
// [R21] Output count sets pixels per pixel clock
// [R22] Strobe times come from cycle counters
// [R23] Shift 32 bits before load; no mid-frame change (a send set in the same CTRL write as start still loads mid-frame)
`timescale 1ns/1ps
module irc_readout_host #(
    parameter int PIX_DIV = 2,
    parameter int CFG_DIV = 4
) (
    input wire logic CLOCK_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic [31:0] REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output logic [31:0] REG_RDATA_O,
    output logic ROW_CLOCK_O,
    output logic ROW_SYNC_O,
    output logic ROW_BLANK_O,
    output logic COL_PRECHARGE_O,
    output logic COLUMN_SAMPLE_HOLD_O,
    output logic VOLT_AVG_O,
    output logic BUS_PRECHARGE_A_O,
    output logic BUS_PRECHARGE_B_O,
    output logic PIX_CLOCK_O,
    output logic COL_SYNC_O,
    output logic CFG_DATA_O,
    output logic CFG_CLOCK_O,
    output logic CFG_LOAD_O,
    input wire logic LINE_END_I,
    input wire logic CFG_CHECK_I
);
    generate
        if (PIX_DIV < 1 || PIX_DIV > 255) begin : g_bad
            $error("irc_readout_host: PIX_DIV out of range");
        end
    endgenerate

    function automatic logic [11:0] at_least_one(input logic [11:0] v);
        at_least_one = (v == 12'h000) ? 12'h001 : v;
    endfunction

    // Register file
    logic [31:0] cfg_q;
    logic [2:0] ctrl_q;
    logic [11:0] lines_q;
    logic [11:0] cols_q;
    logic [4:0] shlen_q;
    logic line_end_q;
    logic cfg_check_q;

    // Sequencer
    irc_pkg::irc_state_t state_q;
    irc_pkg::irc_state_t state_d;
    logic [7:0] cnt_q;
    logic [4:0] sh_cnt_q;
    logic [11:0] lines_left_q;
    logic [11:0] pix_left_q;
    logic [7:0] pix_div_q;
    logic pix_clk_q;
    logic cfg_busy;

    wire wr_cfg_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_CFG);
    wire wr_ctrl_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_CTRL);
    wire wr_lines_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_LINES);
    wire wr_cols_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_COLS);
    wire wr_shlen_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_SHLEN);
    wire wr_stat_w = REG_WR_I && (REG_ADDR_I == irc_pkg::OFS_STAT);
    wire idle_w = (state_q == irc_pkg::ST_IDLE);
    // Config writes and sends only between frames; a send with start loads mid-frame
    wire send_w = wr_ctrl_w && REG_WDATA_I[irc_pkg::CTRL_SEND] && idle_w && !cfg_busy; // [R23]
    wire start_w = wr_ctrl_w && REG_WDATA_I[irc_pkg::CTRL_START] && idle_w && !cfg_busy;
    wire cfg_wr_ok_w = wr_cfg_w && idle_w && !cfg_busy; // [R23]
    wire backup_w = ctrl_q[irc_pkg::CTRL_BACKUP];
    wire buspre_w = ctrl_q[irc_pkg::CTRL_BUSPRE];
    // Averaging only exists in backup timing
    wire avg_w = ctrl_q[irc_pkg::CTRL_AVG] && backup_w; // [R6]

    // Subsampling forces an even column start address
    wire [31:0] cfg_in_w = REG_WDATA_I[irc_pkg::CFG_SUB]
        ? (REG_WDATA_I & ~(32'h0000_0001 << irc_pkg::CFG_XADDR_LSB))
        : REG_WDATA_I; // [R14]
    wire [4:0] sh_in_w = REG_WDATA_I[4:0];
    wire [4:0] sh_clamp_w = (sh_in_w < irc_pkg::SH_MIN_CYC) ? irc_pkg::SH_MIN_CYC
        : (sh_in_w > irc_pkg::SH_MAX_CYC) ? irc_pkg::SH_MAX_CYC : sh_in_w; // [R5]

    wire pix_run_w = (state_q == irc_pkg::ST_XSYNC) || (state_q == irc_pkg::ST_PIX);
    wire pix_tick_w = pix_run_w && (pix_div_q == 8'(PIX_DIV - 1));
    wire pix_rise_w = pix_tick_w && !pix_clk_q;
    wire blank_done_w = (cnt_q == irc_pkg::BLANK_CYC - 8'h01);
    wire rot_done_w = backup_w ? (sh_cnt_q == 5'h00)
        : (cnt_q == irc_pkg::ROT_CYC - 8'h01); // [R2]
    wire blank_entry_w = (state_d == irc_pkg::ST_BLANK) && (state_q != irc_pkg::ST_BLANK);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            irc_pkg::ST_IDLE: begin
                if (start_w) begin
                    state_d = irc_pkg::ST_FSYNC;
                end
            end
            irc_pkg::ST_FSYNC: begin
                if (cnt_q == irc_pkg::SYNC_CYC) begin
                    state_d = irc_pkg::ST_BLANK;
                end
            end
            irc_pkg::ST_LINE: begin
                state_d = irc_pkg::ST_BLANK;
            end
            irc_pkg::ST_BLANK: begin
                if (blank_done_w) begin
                    state_d = irc_pkg::ST_ROTW;
                end
            end
            irc_pkg::ST_ROTW: begin
                if (rot_done_w) begin
                    state_d = avg_w ? irc_pkg::ST_AVG : irc_pkg::ST_XSYNC;
                end
            end
            irc_pkg::ST_AVG: begin
                if (cnt_q == irc_pkg::AVG_CYC - 8'h01) begin
                    state_d = irc_pkg::ST_XSYNC;
                end
            end
            irc_pkg::ST_XSYNC: begin
                if (pix_rise_w) begin
                    state_d = irc_pkg::ST_PIX;
                end
            end
            irc_pkg::ST_PIX: begin
                if (pix_rise_w && pix_left_q == 12'h000) begin
                    state_d = (lines_left_q <= 12'h001) ? irc_pkg::ST_IDLE : irc_pkg::ST_LINE;
                end
            end
            default: begin
                state_d = irc_pkg::ST_IDLE;
            end
        endcase
    end

    // Pin levels decoded from the sequencer, registered below
    wire fsync_w = (state_q == irc_pkg::ST_FSYNC);
    wire blank_w = (state_q == irc_pkg::ST_BLANK);
    wire row_sync_w = fsync_w; // [R20]
    wire row_clk_w = (fsync_w && cnt_q != 8'h00) || blank_w || (state_q == irc_pkg::ST_LINE);
    wire strobe_w = blank_w; // [R1]
    wire bus_pre_w = buspre_w && blank_w && (cnt_q < irc_pkg::PRE_CYC); // [R8] [R9]
    // Standard timing keeps hold low; backup releases it after the pulse
    wire sh_hold_w = backup_w && (sh_cnt_q == 5'h00); // [R3] [R4]
    wire avg_out_w = (state_q == irc_pkg::ST_AVG); // [R7]
    wire col_sync_w = (state_q == irc_pkg::ST_XSYNC); // [R17]

    wire [11:0] line_no_w = idle_w ? 12'h000 : lines_left_q;
    wire [31:0] stat_w = {4'h0, line_no_w, 12'h000, line_end_q, cfg_check_q, !idle_w, cfg_busy};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (REG_ADDR_I)
            irc_pkg::OFS_CFG: rd_mux = cfg_q;
            irc_pkg::OFS_CTRL: rd_mux = {29'h0000_0000, ctrl_q};
            irc_pkg::OFS_LINES: rd_mux = {20'h0_0000, lines_q};
            irc_pkg::OFS_COLS: rd_mux = {20'h0_0000, cols_q};
            irc_pkg::OFS_SHLEN: rd_mux = {27'h000_0000, shlen_q};
            irc_pkg::OFS_STAT: rd_mux = stat_w;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Register writes and read answer
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cfg_q <= irc_pkg::CFG_RST; // [R15]
            ctrl_q <= irc_pkg::CTRL_RST;
            lines_q <= irc_pkg::LINES_RST;
            cols_q <= irc_pkg::COLS_RST;
            shlen_q <= irc_pkg::SH_MAX_CYC;
            REG_RDATA_O <= 32'h0000_0000;
        end else begin
            if (cfg_wr_ok_w) cfg_q <= cfg_in_w;
            if (wr_ctrl_w && idle_w) ctrl_q <= REG_WDATA_I[2:0];
            if (wr_lines_w && idle_w) lines_q <= REG_WDATA_I[11:0];
            if (wr_cols_w && idle_w) cols_q <= REG_WDATA_I[11:0];
            if (wr_shlen_w && idle_w) shlen_q <= sh_clamp_w;
            if (REG_RD_I) REG_RDATA_O <= rd_mux;
        end
    end

    // Device test flags; a new end-of-line beats a clear
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            line_end_q <= 1'b0;
            cfg_check_q <= 1'b0;
        end else begin
            cfg_check_q <= CFG_CHECK_I; // [R18]
            line_end_q <= LINE_END_I ||
                (line_end_q && !(wr_stat_w && REG_WDATA_I[irc_pkg::STAT_LINE_END])); // [R17]
        end
    end

    // Sequencer counters
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            state_q <= irc_pkg::ST_IDLE;
            cnt_q <= 8'h00;
            sh_cnt_q <= 5'h00;
            lines_left_q <= 12'h000;
            pix_left_q <= 12'h000;
        end else begin
            state_q <= state_d;
            cnt_q <= (state_d != state_q) ? 8'h00 : cnt_q + 8'h01; // [R22]
            if (blank_entry_w) begin
                sh_cnt_q <= backup_w ? shlen_q : 5'h00; // [R5]
            end else if (sh_cnt_q != 5'h00) begin
                sh_cnt_q <= sh_cnt_q - 5'h01;
            end
            if (start_w) begin
                lines_left_q <= at_least_one(lines_q);
            end else if (state_q == irc_pkg::ST_PIX && state_d != irc_pkg::ST_PIX) begin
                lines_left_q <= lines_left_q - 12'h001;
            end
            if (state_q == irc_pkg::ST_XSYNC) begin
                pix_left_q <= at_least_one(cols_q) - 12'h001; // [R21]
            end else if (pix_rise_w && pix_left_q != 12'h000) begin
                pix_left_q <= pix_left_q - 12'h001;
            end
        end
    end

    // Pixel clock divider runs only while a line is multiplexed out
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            pix_div_q <= 8'h00;
            pix_clk_q <= 1'b0;
        end else begin
            pix_div_q <= (!pix_run_w || pix_tick_w) ? 8'h00 : pix_div_q + 8'h01;
            if (state_d != irc_pkg::ST_XSYNC && state_d != irc_pkg::ST_PIX) begin
                pix_clk_q <= 1'b0;
            end else if (pix_tick_w) begin
                pix_clk_q <= ~pix_clk_q;
            end
        end
    end

    // Pin registers
    always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            ROW_CLOCK_O <= 1'b0;
            ROW_SYNC_O <= 1'b0;
            ROW_BLANK_O <= 1'b0;
            COL_PRECHARGE_O <= 1'b0;
            COLUMN_SAMPLE_HOLD_O <= 1'b0;
            VOLT_AVG_O <= 1'b0;
            BUS_PRECHARGE_A_O <= 1'b0;
            BUS_PRECHARGE_B_O <= 1'b0;
            COL_SYNC_O <= 1'b0;
        end else begin
            ROW_CLOCK_O <= row_clk_w;
            ROW_SYNC_O <= row_sync_w;
            ROW_BLANK_O <= strobe_w;
            COL_PRECHARGE_O <= strobe_w;
            COLUMN_SAMPLE_HOLD_O <= sh_hold_w;
            VOLT_AVG_O <= avg_out_w;
            BUS_PRECHARGE_A_O <= bus_pre_w;
            BUS_PRECHARGE_B_O <= bus_pre_w;
            COL_SYNC_O <= col_sync_w;
        end
    end

    assign PIX_CLOCK_O = pix_clk_q;

    // Configuration word fields reach the device only through this link
    irc_cfg_serial #(
        .WIDTH(32),
        .DIV(CFG_DIV)
    ) u_cfg (
        .clk_i(CLOCK_I),
        .rst_i(SYS_RST_I),
        .start_i(send_w), // [R16]
        .word_i(cfg_q), // [R10] [R11] [R12] [R13] [R19]
        .busy_o(cfg_busy),
        .data_o(CFG_DATA_O),
        .clock_o(CFG_CLOCK_O),
        .load_o(CFG_LOAD_O)
    );
endmodule // irc_readout_host
